// [hdl/epti_decide.sv]
/*
  Decision logic: whether a frame from a source port leaving on an egress port
  gets the source PVID inserted.
  Assumes frame descriptors are synchronous to ref_clk and ports numbered 1..5.
*/
`timescale 1ns/10ps
module epti_decide
  import epti_pkg::*;
(
  // selection table
  epti_sel_if.user       sel_if,
  // frame query
  input  wire logic [PORT_W-1:0] src_port,
  input  wire logic [PORT_W-1:0] dst_port,
  input  wire logic              frame_tagged,
  output logic                   insert
);
  import epti_pkg::*;

  // rank of egress port among the four ports other than the source, 0 = lowest
  function automatic logic [1:0] other_rank(input logic [PORT_W-1:0] src,
                                            input logic [PORT_W-1:0] dst);
    logic [PORT_W-1:0] r;
    r = (dst > src) ? PORT_W'(dst - 3'd2) : PORT_W'(dst - 3'd1);
    return r[1:0];
  endfunction

  logic [1:0]  rank;
  logic        valid_pair;
  logic [2:0]  src_idx;

  always_comb begin
    valid_pair = (src_port >= 3'd1) && (src_port <= 3'(NUM_PORTS)) &&
                 (dst_port >= 3'd1) && (dst_port <= 3'(NUM_PORTS)) &&
                 (dst_port != src_port);
    rank       = other_rank(src_port, dst_port);
    src_idx    = valid_pair ? 3'(src_port - 3'd1) : 3'd0;
    insert     = 1'b0;
    // tagged frames never re-tagged; others pass unchanged unless selected
    if (valid_pair && !frame_tagged && sel_if.ins_en) begin
      // rank 3..0 maps to bits 3..0
      insert = sel_if.sel[src_idx][rank];
    end
  end
endmodule

// [hdl/epti_top.sv]
/*
  Egress PVID insertion control for a five-port switch.
  Holds one control byte per source port, whose four low bits pick
  the other ports on which untagged frames from that source get the
  source PVID, and a global control byte whose enable bit gates the
  whole feature.
  For each frame descriptor it registers one insert decision and the
  VID to insert, one cycle after the descriptor; every output comes
  straight from a flip-flop.
  Assumes a synchronous byte-wide register port with one-cycle write
  and read strobes, and frame descriptors on ref_clk.
  Register writes and reads never stall; there is no wait state.
  Assumes source and egress ports numbered 1 to 5; any other number,
  or a frame sent back to its own source, is never tagged.
  The tag itself is added downstream in the egress datapath, which
  takes dec_insert and dec_vid while dec_valid is high.
*/
// Summary of operation
// - bit 3: insert PVID at highest other port
// - bit 2: insert at second highest other port
// - bit 1: insert at second lowest other port
// - bit 0: insert at lowest other port
// - insertion only while global enable bit set
// - six RW control bytes (five per port, one global), cleared at reset
`timescale 1ns/10ps
module epti_top
  import epti_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  // register port
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  output logic      [DATA_W-1:0]     reg_rdata,
  output logic                       reg_rvalid,
  // frame descriptor
  input  wire logic                  frm_valid,
  input  wire logic [PORT_W-1:0]     frm_src_port,
  input  wire logic [PORT_W-1:0]     frm_dst_port,
  input  wire logic                  frm_tagged,
  input  wire logic [VID_W-1:0]      frm_src_pvid,
  // decision
  output logic                       dec_valid,
  output logic                       dec_insert,
  output logic      [VID_W-1:0]      dec_vid
);
  import epti_pkg::*;

  epti_sel_if sel_if ();

  // register file state
  logic [SEL_W-1:0]     sel_reg [NUM_PORTS];
  logic [DATA_W-1:0]    glb_reg;

  // address decode, shared by the write and read paths
  logic                 ctrl_hit;
  logic                 glb_hit;
  logic [PORT_W-1:0]    ctrl_idx;
  logic [NUM_PORTS-1:0] ctrl_wr_en;
  logic                 glb_wr_en;

  // read and decision paths
  logic [DATA_W-1:0]    rdata_next;
  logic                 ins_now;
  logic                 ins_take;
  logic [VID_W-1:0]     vid_next;

  // address of the control byte of port index i
  function automatic logic [ADDR_W-1:0] ctrl_offset(
    input int i
  );
    return ADDR_W'(OFS_P1_CTRL + 8'(i) * OFS_PORT_STRIDE);
  endfunction

  // port index for a control byte address, NUM_PORTS when not one
  function automatic int ctrl_index(
    input logic [ADDR_W-1:0] a
  );
    int idx;
    idx = NUM_PORTS;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (a == ctrl_offset(i)) begin
        idx = i;
      end
    end
    return idx;
  endfunction

  // control byte as seen on a read; only the selection field is stored
  function automatic logic [DATA_W-1:0] ctrl_readback(
    input logic [SEL_W-1:0] s
  );
    return {{(DATA_W-SEL_W){1'b0}}, s};
  endfunction

  // decode once per cycle; a read beside a write still sees the old byte
  always_comb begin
    ctrl_hit  = (ctrl_index(reg_addr) < NUM_PORTS);
    ctrl_idx  = ctrl_hit ? PORT_W'(ctrl_index(reg_addr)) : PORT_NONE;
    glb_hit   = (reg_addr == OFS_GLOBAL_CTRL);
    glb_wr_en = reg_wr && glb_hit;
  end

  // one write enable per control byte
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      ctrl_wr_en[i] = reg_wr && ctrl_hit && (ctrl_idx == PORT_W'(i));
    end
  end

  // one control byte per source port; upper bits are dropped on write
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_ctrl
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        sel_reg[p] <= SEL_RESET;
      end else if (ctrl_wr_en[p]) begin
        sel_reg[p] <= reg_wdata[SEL_W-1:0];
      end
    end
  end

  // global control; only the enable bit acts here, others kept for readback
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      glb_reg <= GLOBAL_RESET;
    end else if (glb_wr_en) begin
      glb_reg <= reg_wdata;
    end
  end

  // unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    if (glb_hit) begin
      rdata_next = glb_reg;
    end else if (ctrl_hit) begin
      rdata_next = ctrl_readback(sel_reg[ctrl_idx]);
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // read data holds until the next read, so software may take it late
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // selection table to the decision logic
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      sel_if.sel[i] = sel_reg[i];
    end
  end

  // feature enable; while clear no frame is tagged here at all
  always_comb begin
    sel_if.ins_en = glb_reg[GLB_INS_EN_BIT];
  end

  // per-frame decision is combinational and registered below
  epti_decide u_decide (
    .sel_if       (sel_if),
    .src_port     (frm_src_port),
    .dst_port     (frm_dst_port),
    .frame_tagged (frm_tagged),
    .insert       (ins_now)
  );

  // an insert only counts for a valid descriptor
  always_comb begin
    ins_take = frm_valid && ins_now;
  end

  // vid only travels with an insert, so an idle output carries nothing stale
  always_comb begin
    vid_next = '0;
    if (ins_take) begin
      vid_next = frm_src_pvid;
    end
  end

  // descriptor answered one cycle after frm_valid
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= frm_valid;
    end
  end

  // insert decision, never high without dec_valid
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_insert <= 1'b0;
    end else begin
      dec_insert <= ins_take;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_vid <= '0;
    end else begin
      dec_vid <= vid_next;
    end
  end
endmodule

// [include/epti_pkg.sv]
/*
  Package for the egress PVID insertion block: register offsets, field positions,
  reset values and port numbering.
  Assumes one switch core clock and an 8-bit register port with byte addresses.
*/
package epti_pkg;
  localparam int          NUM_PORTS       = 5;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          PORT_W          = 3;
  localparam int          VID_W           = 12;
  // control byte offsets, ports 1 to 5
  localparam logic [7:0]  OFS_P1_CTRL     = 8'hB0;
  localparam logic [7:0]  OFS_P2_CTRL     = 8'hC0;
  localparam logic [7:0]  OFS_P3_CTRL     = 8'hD0;
  localparam logic [7:0]  OFS_P4_CTRL     = 8'hE0;
  localparam logic [7:0]  OFS_P5_CTRL     = 8'hF0;
  localparam logic [7:0]  OFS_PORT_STRIDE = 8'h10;
  // global control register holding the feature enable
  localparam logic [7:0]  OFS_GLOBAL_CTRL = 8'h87;
  localparam int          GLB_INS_EN_BIT  = 2;
  // selection fields inside a control byte
  localparam int          SEL_HIGHEST_BIT = 3;
  localparam int          SEL_HIGH2_BIT   = 2;
  localparam int          SEL_LOW2_BIT    = 1;
  localparam int          SEL_LOWEST_BIT  = 0;
  localparam int          SEL_W           = 4;
  localparam logic [3:0]  SEL_RESET       = 4'h0;
  localparam logic [7:0]  GLOBAL_RESET    = 8'h00;
  localparam logic [2:0]  PORT_NONE       = 3'h0;
endpackage

// [include/epti_sel_if.sv]
/*
  Interface carrying the selection table and global enable from the register
  file to the per-frame decision logic.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface epti_sel_if;
  import epti_pkg::*;
  logic [SEL_W-1:0] sel [NUM_PORTS];
  logic             ins_en;
  modport regs (output sel, output ins_en);
  modport user (input sel, input ins_en);
endinterface

// [tb/epti_props.sv]
/* checker for the insert decision and register port of epti_top
   assumes one ref_clk and nrst asynchronous active low */
`timescale 1ns/10ps
module epti_props
  import epti_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  // frame query and decision
  input wire logic        frm_valid,
  input wire logic [2:0]  frm_src_port,
  input wire logic [2:0]  frm_dst_port,
  input wire logic        frm_tagged,
  input wire logic [11:0] frm_src_pvid,
  input wire logic        dec_valid,
  input wire logic        dec_insert,
  input wire logic [11:0] dec_vid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [3:0] sel_q [8];
  logic       en_q;
  // rank of the egress port among the four others
  wire  [2:0] rk = frm_dst_port - 3'h1 - {2'h0, frm_dst_port > frm_src_port};
  wire        ok = frm_valid && !frm_tagged && frm_src_port != frm_dst_port
                   && frm_src_port inside {[1:5]} && frm_dst_port inside {[1:5]};
  wire        hit = ok && en_q && sel_q[frm_src_port][rk];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= '{default: '0};
      en_q  <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_GLOBAL_CTRL)
        en_q <= reg_wdata[GLB_INS_EN_BIT];
      if (reg_addr[3:0] == 4'h0 && reg_addr[7:4] >= 4'hB)
        sel_q[reg_addr[7:4] - 4'hA] <= reg_wdata[3:0];
    end
  end
  sequence q_ask(int k);
    ok && rk == k;
  endsequence
  pick_hi_a: assert property (q_ask(3) |=> dec_insert == $past(hit))
    else $error("highest port decision wrong");
  pick_hi2_a: assert property (q_ask(2) |=> dec_insert == $past(hit))
    else $error("second highest port decision wrong");
  pick_lo2_a: assert property (q_ask(1) |=> dec_insert == $past(hit))
    else $error("second lowest port decision wrong");
  pick_lo_a: assert property (q_ask(0) |=> dec_insert == $past(hit))
    else $error("lowest port decision wrong");
  glob_en_a: assert property (frm_valid && !en_q |=> !dec_insert)
    else $error("insert while globally disabled");
  rd_byte_a: assert property (reg_rd |=> reg_rvalid && (reg_rdata[7:4] == 4'h0 || $past(reg_addr) == OFS_GLOBAL_CTRL))
    else $error("read answer late or upper bits set");
  no_retag_a: assert property (frm_valid && frm_tagged |=> dec_valid && !dec_insert)
    else $error("tagged frame marked for insert");
  vid_carry_a: assert property (frm_valid ##1 dec_insert |-> dec_vid == $past(frm_src_pvid))
    else $error("inserted vid differs from source pvid");
endmodule
bind epti_top epti_props props (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .frm_valid(frm_valid), .frm_src_port(frm_src_port),
  .frm_dst_port(frm_dst_port), .frm_tagged(frm_tagged), .frm_src_pvid(frm_src_pvid),
  .dec_valid(dec_valid), .dec_insert(dec_insert), .dec_vid(dec_vid));

// [tb/test_egress_pvid_tag_insertion.sv]
/* self-checking bench for epti_top
   assumes 50 MHz ref_clk, inputs driven on the falling edge */
`timescale 1ns/10ps
module test_egress_pvid_tag_insertion;
  import epti_pkg::*;
  logic        ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        frm_valid = 1'b0, frm_tagged = 1'b0, reg_rvalid, dec_valid, dec_insert;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0]  frm_src_port = 3'h0, frm_dst_port = 3'h0;
  logic [11:0] frm_src_pvid = 12'h000, dec_vid;
  int          errors = 0, checks_done = 0;
  // egress port that each selection bit picks, per source port 1 to 5
  int          egress [5][4] = '{'{2, 3, 4, 5}, '{1, 3, 4, 5}, '{1, 2, 4, 5},
                                 '{1, 2, 3, 5}, '{1, 2, 3, 4}};
  epti_top dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .frm_valid(frm_valid), .frm_src_port(frm_src_port), .frm_dst_port(frm_dst_port),
    .frm_tagged(frm_tagged), .frm_src_pvid(frm_src_pvid), .dec_valid(dec_valid),
    .dec_insert(dec_insert), .dec_vid(dec_vid));
  task automatic chk(string name, logic [11:0] exp, logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge ref_clk);
    chk("reg_rvalid idle", 12'h000, {11'h0, reg_rvalid});
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk("reg_rvalid", 12'h001, {11'h0, reg_rvalid});
    chk("reg_rdata", {4'h0, e}, {4'h0, reg_rdata});
  endtask
  task automatic ask(logic [2:0] s, logic [2:0] d, logic t, logic e);
    @(negedge ref_clk);
    chk("dec_valid idle", 12'h000, {11'h0, dec_valid});
    {frm_valid, frm_src_port, frm_dst_port, frm_tagged} = {1'b1, s, d, t};
    frm_src_pvid = {s, d, 6'h2A};
    @(negedge ref_clk);
    frm_valid = 1'b0;
    chk("dec_valid", 12'h001, {11'h0, dec_valid});
    chk("dec_insert", {11'h0, e}, {11'h0, dec_insert});
    chk("dec_vid", e ? frm_src_pvid : 12'h000, dec_vid);
  endtask
  task automatic t_regs();
    for (int p = 0; p < 5; p++)
      rd(OFS_P1_CTRL + 8'(p * 16), 8'h00);
    rd(OFS_GLOBAL_CTRL, 8'h00);
    wr(OFS_GLOBAL_CTRL, 8'hFB);
    rd(OFS_GLOBAL_CTRL, 8'hFB);
    wr(OFS_P3_CTRL, 8'hFA);
    rd(OFS_P3_CTRL, 8'h0A);
    wr(8'hB1, 8'h55);
    rd(8'hB1, 8'h00);
  endtask
  // one selection bit at a time, every source against every egress port
  task automatic t_map();
    wr(OFS_GLOBAL_CTRL, 8'h04);
    for (int s = 1; s <= 5; s++)
      for (int k = 0; k < 4; k++) begin
        wr(OFS_P1_CTRL + 8'((s - 1) * 16), 8'(1 << k));
        for (int d = 1; d <= 5; d++)
          ask(3'(s), 3'(d), 1'b0, d == egress[s - 1][k]);
        ask(3'(s), 3'(s % 5 + 1), 1'b1, 1'b0);
      end
  endtask
  task automatic t_glob();
    wr(OFS_P2_CTRL, 8'h0F);
    wr(OFS_GLOBAL_CTRL, 8'h00);
    ask(3'h2, 3'h4, 1'b0, 1'b0);
    wr(OFS_GLOBAL_CTRL, 8'h04);
    ask(3'h2, 3'h4, 1'b0, 1'b1);
    ask(3'h2, 3'h2, 1'b0, 1'b0);
  endtask
  // reset in mid-run clears the control bytes and holds reg_rdata, dec_valid and dec_insert low
  task automatic t_rst();
    rd(OFS_P2_CTRL, 8'h0F);
    @(negedge ref_clk);
    {nrst, frm_valid, frm_src_port, frm_dst_port, frm_tagged} = {1'b0, 1'b1, 3'h2, 3'h4, 1'b0};
    @(negedge ref_clk);
    chk("reg_rdata in reset", 12'h000, {4'h0, reg_rdata});
    chk("dec_valid in reset", 12'h000, {11'h0, dec_valid});
    chk("dec_insert in reset", 12'h000, {11'h0, dec_insert});
    {nrst, frm_valid} = 2'b10;
    for (int p = 0; p < 5; p++)
      rd(OFS_P1_CTRL + 8'(p * 16), 8'h00);
    rd(OFS_GLOBAL_CTRL, 8'h00);
    wr(OFS_GLOBAL_CTRL, 8'h04);
    ask(3'h2, 3'h4, 1'b0, 1'b0);
  endtask
  task automatic complete_run();
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    t_regs();
    t_map();
    t_glob();
    t_rst();
    complete_run();
  end
endmodule
